// [rtl/asr_pkg.sv]
// constants shared by the asynchronous serial receiver
// assumes an 8-bit register port with 3-bit addresses
package asr_pkg;

  // register addresses
  localparam logic [2:0] ADDR_CTRL_ONE   = 3'h0;
  localparam logic [2:0] ADDR_CTRL_TWO   = 3'h1;
  localparam logic [2:0] ADDR_STATUS     = 3'h2;
  localparam logic [2:0] ADDR_CTRL_THREE = 3'h3;
  localparam logic [2:0] ADDR_DATA       = 3'h4;
  localparam logic [2:0] ADDR_BAUD_HI    = 3'h5;
  localparam logic [2:0] ADDR_BAUD_LO    = 3'h6;

  // control one fields
  localparam int C1_NINE_BIT_MODE   = 4;
  localparam int C1_SLEEP_EXIT      = 3;
  localparam int C1_IDLE_COUNT_SEL  = 2;
  localparam int C1_IDLE_IN_SLEEP   = 1;
  // control two fields
  localparam int C2_RX_ENABLE       = 2;
  localparam int C2_RX_SLEEP        = 1;
  // status one fields
  localparam int S1_RX_FULL         = 5;
  localparam int S1_IDLE            = 4;
  localparam int S1_OVERRUN         = 3;
  localparam int S1_NOISE           = 2;
  localparam int S1_FRAMING         = 1;
  // control three fields
  localparam int C3_NINTH_BIT       = 7;
  localparam int C3_RX_INVERT       = 4;
  // baud divisor split
  localparam int BAUD_HI_BITS       = 5;

  // reset values
  localparam logic [12:0] BAUD_RESET = 13'h0000;

  // sample slot numbers within one bit time
  localparam logic [4:0] RT_FIRST   = 5'h01;
  localparam logic [4:0] RT_START_A = 5'h03;
  localparam logic [4:0] RT_START_B = 5'h05;
  localparam logic [4:0] RT_START_C = 5'h07;
  localparam logic [4:0] RT_MID_A   = 5'h08;
  localparam logic [4:0] RT_MID_B   = 5'h09;
  localparam logic [4:0] RT_MID_C   = 5'h0A;
  localparam logic [4:0] RT_LAST    = 5'h10;

  // frame geometry: index of the stop bit and of the first data bit
  localparam logic [3:0] STOP_IDX_8 = 4'h9;
  localparam logic [3:0] STOP_IDX_9 = 4'hA;
  localparam logic [3:0] FIRST_DATA = 4'h1;
  // idle character length in sample ticks (bits times sixteen)
  localparam logic [7:0] IDLE_TICKS_8 = 8'hA0;
  localparam logic [7:0] IDLE_TICKS_9 = 8'hB0;
  // edge detector history that precedes a falling edge
  localparam logic [2:0] EDGE_ONES  = 3'h7;

  // receiver sequencer states
  typedef enum logic [1:0] {
    ASR_HUNT  = 2'b00,
    ASR_START = 2'b01,
    ASR_BITS  = 2'b10
  } asr_rx_state_e;

endpackage

// [rtl/asr_receiver.sv]
// asynchronous serial receiver with sleep and wakeup
// assumes a synchronous receive input and a one-cycle register port
//
// Design decisions made here: strobed register access and the register addresses.
`timescale 1ns/10ps
`default_nettype none

module asr_receiver #(
  parameter int BAUD_W = 13
) (
  input  wire logic       mclk_i,
  input  wire logic       rst_i,
  input  wire logic       rx_i,
  input  wire logic [2:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  output logic      [7:0] rdata_o
);

  logic              nine_bit_mode_reg;
  logic              sleep_exit_method_reg;
  logic              idle_count_start_select_reg;
  logic              idle_flag_in_sleep_reg;
  logic              receiver_enable_reg;
  logic              rx_sleep_reg;
  logic              rx_invert_reg;
  logic [BAUD_W-1:0] baud_div_reg;
  logic [BAUD_W-1:0] baud_cnt_reg;
  logic [BAUD_W-1:0] baud_cnt_next;
  logic              rx_on;
  logic              rt_tick;
  logic              rxd;
  logic              edge_seen;
  logic [2:0]        edge_hist_reg;
  asr_pkg::asr_rx_state_e state_reg;
  logic [4:0]        rt_reg;
  logic [4:0]        slot;
  logic [3:0]        bit_idx_reg;
  logic [3:0]        stop_idx;
  logic [1:0]        samp_reg;
  logic              noise_reg;
  logic [8:0]        shift_reg;
  logic              bit_vote;
  logic              bit_noisy;
  logic              start_ok;
  logic              decide;
  logic              new_bit;
  logic              frame_done;
  logic              msb_decide;
  logic              is_break;
  logic              framing;
  logic              flags_ok;
  logic              xfer;
  logic              overrun_set;
  logic [7:0]        idle_cnt_reg;
  logic [7:0]        idle_target;
  logic              idle_hold;
  logic              idle_event;
  logic              idle_armed_reg;
  logic              idle_set;
  logic              wake_idle;
  logic              wake_addr;
  logic              rx_buffer_full_flag_reg;
  logic              idle_flag_reg;
  logic              overrun_flag_reg;
  logic              noise_flag_reg;
  logic              framing_error_flag_reg;
  logic [7:0]        rx_data_reg;
  logic              rx_ninth_bit_reg;
  logic [4:0]        clr_armed_reg;
  logic [4:0]        clr_now;
  logic [4:0]        flags_now;
  logic              rd_data;
  logic              rd_status;
  logic [7:0]        rd_val;

  // register port write decode
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      nine_bit_mode_reg           <= 1'b0;
      sleep_exit_method_reg       <= 1'b0;
      idle_count_start_select_reg <= 1'b0;
      idle_flag_in_sleep_reg      <= 1'b0;
      receiver_enable_reg         <= 1'b0;
      rx_invert_reg               <= 1'b0;
      baud_div_reg                <= asr_pkg::BAUD_RESET;
    end
    else if (wr_i)
    begin
      if (addr_i == asr_pkg::ADDR_CTRL_ONE)
      begin
        nine_bit_mode_reg           <= wdata_i[asr_pkg::C1_NINE_BIT_MODE];
        sleep_exit_method_reg       <= wdata_i[asr_pkg::C1_SLEEP_EXIT];
        idle_count_start_select_reg <= wdata_i[asr_pkg::C1_IDLE_COUNT_SEL];
        idle_flag_in_sleep_reg      <= wdata_i[asr_pkg::C1_IDLE_IN_SLEEP];
      end
      else if (addr_i == asr_pkg::ADDR_CTRL_TWO)
      begin
        receiver_enable_reg <= wdata_i[asr_pkg::C2_RX_ENABLE];
      end
      else if (addr_i == asr_pkg::ADDR_CTRL_THREE)
      begin
        rx_invert_reg <= wdata_i[asr_pkg::C3_RX_INVERT];
      end
      else if (addr_i == asr_pkg::ADDR_BAUD_HI)
      begin
        baud_div_reg[BAUD_W-1:8] <= wdata_i[asr_pkg::BAUD_HI_BITS-1:0];
      end
      else if (addr_i == asr_pkg::ADDR_BAUD_LO)
      begin
        baud_div_reg[7:0] <= wdata_i;
      end
    end
  end

  // sixteen-times baud tick from the bus clock divider
  assign rx_on = receiver_enable_reg && (baud_div_reg != '0);
  assign baud_cnt_next = baud_cnt_reg + 1'b1;
  assign rt_tick = rx_on && (baud_cnt_next == baud_div_reg);

  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
      baud_cnt_reg <= '0;
    else if (!rx_on || rt_tick)
      baud_cnt_reg <= '0;
    else
      baud_cnt_reg <= baud_cnt_next;
  end

  // input polarity and edge detection
  assign rxd = rx_i ^ rx_invert_reg;
  assign edge_seen = (edge_hist_reg == asr_pkg::EDGE_ONES) && !rxd;

  // slot following the one last sampled, wrapping after sixteen
  assign slot = (rt_reg == asr_pkg::RT_LAST) ? asr_pkg::RT_FIRST
                                             : 5'(rt_reg + 5'h01);
  assign stop_idx = nine_bit_mode_reg ? asr_pkg::STOP_IDX_9
                                      : asr_pkg::STOP_IDX_8;

  // majority of the two stored samples and the present one
  assign bit_vote = (samp_reg[0] & samp_reg[1]) |
                    (samp_reg[0] & rxd) | (samp_reg[1] & rxd);
  assign bit_noisy = !((samp_reg[0] == rxd) && (samp_reg[1] == rxd));
  // at slot 7 at most one of the three start samples may be high
  assign start_ok = !bit_vote;

  assign decide = rt_tick && (state_reg == asr_pkg::ASR_BITS) &&
                  (slot == asr_pkg::RT_MID_C);
  assign new_bit = (slot == asr_pkg::RT_FIRST) ||
                   (edge_seen && (slot >= asr_pkg::RT_MID_C));
  assign frame_done = decide && (bit_idx_reg == stop_idx);
  assign msb_decide = decide && (bit_idx_reg == 4'(stop_idx - 4'h1));
  assign is_break = !bit_vote &&
                    (nine_bit_mode_reg ? (shift_reg == 9'h000)
                                       : (shift_reg[8:1] == 8'h00));
  assign framing = frame_done && !bit_vote;

  // receive sequencer: start check, bit sampling, resync
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state_reg   <= asr_pkg::ASR_HUNT;
      rt_reg      <= asr_pkg::RT_FIRST;
      bit_idx_reg <= 4'h0;
      samp_reg    <= 2'h0;
      noise_reg   <= 1'b0;
      shift_reg   <= 9'h000;
    end
    else if (!rx_on)
    begin
      state_reg <= asr_pkg::ASR_HUNT;
    end
    else if (rt_tick)
    begin
      case (state_reg)
        asr_pkg::ASR_HUNT:
        begin
          if (edge_seen)
          begin
            state_reg   <= asr_pkg::ASR_START;
            rt_reg      <= asr_pkg::RT_FIRST;
            bit_idx_reg <= 4'h0;
            noise_reg   <= 1'b0;
            samp_reg    <= 2'h0;
          end
        end
        asr_pkg::ASR_START:
        begin
          rt_reg <= slot;
          if (slot == asr_pkg::RT_START_A || slot == asr_pkg::RT_MID_A)
            samp_reg[0] <= rxd;
          else if (slot == asr_pkg::RT_START_B ||
                   slot == asr_pkg::RT_MID_B)
            samp_reg[1] <= rxd;
          else if (slot == asr_pkg::RT_START_C)
          begin
            if (!start_ok)
              state_reg <= asr_pkg::ASR_HUNT;
            else if (samp_reg != 2'h0 || rxd)
              noise_reg <= 1'b1;
          end
          else if (slot == asr_pkg::RT_MID_C)
          begin
            // start level stays 0 whatever the mid samples say
            if (samp_reg != 2'h0 || rxd)
              noise_reg <= 1'b1;
          end
          else if (slot == asr_pkg::RT_LAST)
          begin
            // the next slot 1 steps the index up to the first data bit
            state_reg   <= asr_pkg::ASR_BITS;
            bit_idx_reg <= 4'(asr_pkg::FIRST_DATA - 4'h1);
          end
        end
        asr_pkg::ASR_BITS:
        begin
          // a falling edge marks the start of a bit time
          rt_reg <= edge_seen ? asr_pkg::RT_FIRST : slot;
          if (new_bit && bit_idx_reg != stop_idx)
          begin
            bit_idx_reg <= 4'(bit_idx_reg + 4'h1);
          end
          if (edge_seen && slot < asr_pkg::RT_MID_C)
            samp_reg <= 2'h0;
          else if (slot == asr_pkg::RT_MID_A)
            samp_reg[0] <= rxd;
          else if (slot == asr_pkg::RT_MID_B)
            samp_reg[1] <= rxd;
          else if (slot == asr_pkg::RT_MID_C)
          begin
            if (bit_noisy)
              noise_reg <= 1'b1;
            if (bit_idx_reg == stop_idx)
              state_reg <= asr_pkg::ASR_HUNT;
            else
              shift_reg <= {bit_vote, shift_reg[8:1]};
          end
        end
        default:
          state_reg <= asr_pkg::ASR_HUNT;
      endcase
    end
  end

  // edge detector history, preloaded after a non-break framing error
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
      edge_hist_reg <= 3'h0;
    else if (!rx_on)
      edge_hist_reg <= 3'h0;
    else if (rt_tick)
    begin
      if (framing && !is_break)
        edge_hist_reg <= asr_pkg::EDGE_ONES;
      else
        edge_hist_reg <= {edge_hist_reg[1:0], rxd};
    end
  end

  // idle line counter in sample ticks
  assign idle_target = nine_bit_mode_reg ? asr_pkg::IDLE_TICKS_9
                                         : asr_pkg::IDLE_TICKS_8;
  assign idle_hold = !rxd ||
    (idle_count_start_select_reg && state_reg != asr_pkg::ASR_HUNT);
  assign idle_event = rt_tick && !idle_hold &&
                      (8'(idle_cnt_reg + 8'h01) == idle_target);

  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
      idle_cnt_reg <= 8'h00;
    else if (!rx_on)
      idle_cnt_reg <= 8'h00;
    else if (rt_tick)
    begin
      if (idle_hold)
        idle_cnt_reg <= 8'h00;
      else if (idle_cnt_reg != idle_target)
        idle_cnt_reg <= 8'(idle_cnt_reg + 8'h01);
    end
  end

  // wakeup from sleep
  assign wake_idle = idle_event && !sleep_exit_method_reg &&
                     rx_sleep_reg;
  assign wake_addr = msb_decide && sleep_exit_method_reg &&
                     rx_sleep_reg && bit_vote;

  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
      rx_sleep_reg <= 1'b0;
    else if (wr_i && addr_i == asr_pkg::ADDR_CTRL_TWO)
      rx_sleep_reg <= wdata_i[asr_pkg::C2_RX_SLEEP];
    else if (wake_idle || wake_addr)
      rx_sleep_reg <= 1'b0;
  end

  // character transfer decisions
  assign flags_ok = !rx_sleep_reg;
  assign xfer = frame_done && flags_ok && !framing_error_flag_reg &&
                !rx_buffer_full_flag_reg;
  assign overrun_set = frame_done && flags_ok &&
                       !framing_error_flag_reg &&
                       rx_buffer_full_flag_reg;
  assign idle_set = idle_event && idle_armed_reg &&
                    (!rx_sleep_reg || idle_flag_in_sleep_reg);

  // receive data buffer and ninth bit
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      rx_data_reg      <= 8'h00;
      rx_ninth_bit_reg <= 1'b0;
    end
    else if (xfer)
    begin
      rx_data_reg <= nine_bit_mode_reg ? shift_reg[7:0]
                                       : shift_reg[8:1];
      if (nine_bit_mode_reg)
        rx_ninth_bit_reg <= shift_reg[8];
    end
  end

  // two-access clear: status read arms, data read clears
  assign rd_status = rd_i && (addr_i == asr_pkg::ADDR_STATUS);
  assign rd_data = rd_i && (addr_i == asr_pkg::ADDR_DATA);
  assign flags_now = {rx_buffer_full_flag_reg, idle_flag_reg,
                      overrun_flag_reg, noise_flag_reg,
                      framing_error_flag_reg};
  assign clr_now = rd_data ? clr_armed_reg : 5'h00;

  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
      clr_armed_reg <= 5'h00;
    else if (rd_status)
      clr_armed_reg <= flags_now;
    else if (rd_data)
      clr_armed_reg <= 5'h00;
  end

  // status flags, a set in the clearing cycle wins
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      rx_buffer_full_flag_reg <= 1'b0;
      idle_flag_reg           <= 1'b0;
      overrun_flag_reg        <= 1'b0;
      noise_flag_reg          <= 1'b0;
      framing_error_flag_reg  <= 1'b0;
    end
    else
    begin
      rx_buffer_full_flag_reg <= xfer ||
        (rx_buffer_full_flag_reg && !clr_now[4]);
      idle_flag_reg <= idle_set || (idle_flag_reg && !clr_now[3]);
      overrun_flag_reg <= overrun_set ||
        (overrun_flag_reg && !clr_now[2]);
      noise_flag_reg <= (xfer && (noise_reg || bit_noisy)) ||
        (noise_flag_reg && !clr_now[1]);
      framing_error_flag_reg <= (xfer && framing) ||
        (framing_error_flag_reg && !clr_now[0]);
    end
  end

  // idle flag may set again only after a new character
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
      idle_armed_reg <= 1'b0;
    else if (xfer)
      idle_armed_reg <= 1'b1;
    else if (idle_set)
      idle_armed_reg <= 1'b0;
  end

  // read value mux
  always_comb
  begin
    rd_val = 8'h00;
    if (addr_i == asr_pkg::ADDR_CTRL_ONE)
    begin
      rd_val[asr_pkg::C1_NINE_BIT_MODE]  = nine_bit_mode_reg;
      rd_val[asr_pkg::C1_SLEEP_EXIT]     = sleep_exit_method_reg;
      rd_val[asr_pkg::C1_IDLE_COUNT_SEL] = idle_count_start_select_reg;
      rd_val[asr_pkg::C1_IDLE_IN_SLEEP]  = idle_flag_in_sleep_reg;
    end
    else if (addr_i == asr_pkg::ADDR_CTRL_TWO)
    begin
      rd_val[asr_pkg::C2_RX_ENABLE] = receiver_enable_reg;
      rd_val[asr_pkg::C2_RX_SLEEP]  = rx_sleep_reg;
    end
    else if (addr_i == asr_pkg::ADDR_STATUS)
    begin
      rd_val[asr_pkg::S1_RX_FULL] = rx_buffer_full_flag_reg;
      rd_val[asr_pkg::S1_IDLE]    = idle_flag_reg;
      rd_val[asr_pkg::S1_OVERRUN] = overrun_flag_reg;
      rd_val[asr_pkg::S1_NOISE]   = noise_flag_reg;
      rd_val[asr_pkg::S1_FRAMING] = framing_error_flag_reg;
    end
    else if (addr_i == asr_pkg::ADDR_CTRL_THREE)
    begin
      rd_val[asr_pkg::C3_NINTH_BIT] = rx_ninth_bit_reg;
      rd_val[asr_pkg::C3_RX_INVERT] = rx_invert_reg;
    end
    else if (addr_i == asr_pkg::ADDR_DATA)
    begin
      rd_val = rx_data_reg;
    end
    else if (addr_i == asr_pkg::ADDR_BAUD_HI)
    begin
      rd_val[asr_pkg::BAUD_HI_BITS-1:0] = baud_div_reg[BAUD_W-1:8];
    end
    else if (addr_i == asr_pkg::ADDR_BAUD_LO)
    begin
      rd_val = baud_div_reg[7:0];
    end
  end

  // read data stand only in the cycle after the strobe
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
      rdata_o <= 8'h00;
    else if (rd_i)
      rdata_o <= rd_val;
    else
      rdata_o <= 8'h00;
  end

endmodule

`default_nettype wire

// [test/asr_receiver_asserts.sv]
// checker for the serial receiver register port
// bound to the receiver top; sees only its ports
`timescale 1ns/10ps
`default_nettype none
module asr_receiver_asserts (
  input wire logic       mclk_i,
  input wire logic       rst_i,
  input wire logic       rx_i,
  input wire logic [2:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic       wr_i,
  input wire logic       rd_i,
  input wire logic [7:0] rdata_o
);
  logic [7:0] c1_reg;
  logic       inv_reg;
  logic       en_reg;
  logic       slp_reg;
  logic       on_reg;
  logic       st_rd;
  logic       c2_rd;
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  // strobes of the reads that the checks look at
  assign st_rd = rd_i && addr_i == asr_pkg::ADDR_STATUS;
  assign c2_rd = rd_i && addr_i == asr_pkg::ADDR_CTRL_TWO;
  // shadow of what software last wrote
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      c1_reg <= 8'h00;
      inv_reg <= 1'b0;
      en_reg <= 1'b0;
      slp_reg <= 1'b0;
      on_reg <= 1'b0;
    end
    else if (wr_i && addr_i == asr_pkg::ADDR_CTRL_ONE)
      c1_reg <= wdata_i & 8'h1E;
    else if (wr_i && addr_i == asr_pkg::ADDR_CTRL_THREE)
      inv_reg <= wdata_i[4];
    else if (wr_i && addr_i == asr_pkg::ADDR_CTRL_TWO)
    begin
      en_reg <= wdata_i[2];
      slp_reg <= wdata_i[1];
      on_reg <= on_reg | wdata_i[2];
    end
  end
  property p_quiet; !$past(rd_i) |-> rdata_o == 8'h00;
  endproperty
  a_quiet: assert property (p_quiet)
    else $error("read data not idle");
  property p_err; st_rd |=> !(rdata_o[2] || rdata_o[1]) || rdata_o[5];
  endproperty
  a_err: assert property (p_err)
    else $error("error flag without full flag");
  property p_stz; st_rd |=> (rdata_o & 8'hC1) == 8'h00;
  endproperty
  a_stz: assert property (p_stz)
    else $error("unused status bits set");
  property p_c1; rd_i && addr_i == 3'h0 |=> rdata_o == c1_reg;
  endproperty
  a_c1: assert property (p_c1)
    else $error("control one readback wrong");
  property p_c3; rd_i && addr_i == 3'h3 |=> rdata_o[6:0] == {2'h0, inv_reg, 4'h0};
  endproperty
  a_c3: assert property (p_c3)
    else $error("invert bit readback wrong");
  property p_c2; c2_rd |=> rdata_o[7:2] == {5'h00, en_reg} && !rdata_o[0];
  endproperty
  a_c2: assert property (p_c2)
    else $error("enable bit readback wrong");
  property p_slp; c2_rd ##1 rdata_o[1] |-> slp_reg;
  endproperty
  a_slp: assert property (p_slp)
    else $error("sleep set without software");
  property p_off; st_rd && !on_reg |=> rdata_o == 8'h00;
  endproperty
  a_off: assert property (p_off)
    else $error("flags while never enabled");
  c_full: cover property (st_rd ##1 rdata_o[5]);
  c_ovr: cover property (st_rd ##1 rdata_o[3]);
  c_wake: cover property (c2_rd && slp_reg ##1 !rdata_o[1]);
endmodule
`default_nettype wire

// [test/asr_line_model.sv]
// model of the remote transmitter on the receive line
// idles high between frames; a bit lasts BIT_CYC clocks
`timescale 1ns/10ps
`default_nettype none
module asr_line_model #(
  parameter int BIT_CYC = 32
) (
  input  wire logic       mclk_i,
  input  wire logic       go_i,
  input  wire logic [8:0] data_i,
  input  wire logic       nine_i,
  input  wire logic       stop_bad_i,
  input  wire logic       noise_i,
  input  wire logic       inv_i,
  output logic            line_o,
  output logic            busy_o
);
  logic        lvl;
  logic [10:0] fr;
  // polarity follows the receiver's inversion setting
  assign line_o = lvl ^ inv_i;
  // start, data lsb first, stop, then one idle bit in eight-bit frames only
  initial
  begin
    lvl = 1'b1;
    busy_o = 1'b0;
    forever
    begin
      @(posedge mclk_i);
      if (go_i)
      begin
        busy_o <= 1'b1;
        fr = nine_i ? {~stop_bad_i, data_i, 1'b0}
                    : {1'b1, ~stop_bad_i, data_i[7:0], 1'b0};
        for (int i = 0; i < 11; i++)
          for (int c = 0; c < BIT_CYC; c++)
          begin
            lvl <= fr[i] ^ (noise_i && i == 3 && c inside {16, 17});
            @(posedge mclk_i);
          end
        busy_o <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// [test/asr_receiver_tb_top.sv]
// self-checking bench for the serial receiver
// line model drives rx; divisor 2 gives 32 clocks a bit
`timescale 1ns/10ps
`default_nettype none
bind asr_receiver asr_receiver_asserts asr_receiver_asserts_i (
  .mclk_i(mclk_i), .rst_i(rst_i), .rx_i(rx_i), .addr_i(addr_i),
  .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o));
module asr_receiver_tb_top;
  logic       mclk, rst, wr_s, rd_s, line;
  logic       m_go, m_nine, m_bad, m_noise, m_inv, m_busy;
  logic [2:0] addr;
  logic [7:0] wdata, rdata, q, b;
  logic [8:0] m_data;
  int         failures, samples_checked, seed;
  asr_receiver asr_receiver_i (.mclk_i(mclk), .rst_i(rst), .rx_i(line),
    .addr_i(addr), .wdata_i(wdata), .wr_i(wr_s), .rd_i(rd_s),
    .rdata_o(rdata));
  asr_line_model #(.BIT_CYC(32)) asr_line_model_i (.mclk_i(mclk),
    .go_i(m_go), .data_i(m_data), .nine_i(m_nine), .stop_bad_i(m_bad),
    .noise_i(m_noise), .inv_i(m_inv), .line_o(line), .busy_o(m_busy));
  // 20 MHz clock
  initial
  begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  task automatic test_done;
    $display("checked %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] s, e);
    samples_checked++;
    if (s !== e)
    begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge mclk);
    wr_s <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] v);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge mclk);
    rd_s <= 1'b0;
    #1 v = rdata;
    @(posedge mclk);
  endtask
  task automatic rc(input logic [2:0] a, input logic [7:0] e, string nm);
    logic [7:0] v;
    rd(a, v);
    chk(nm, v, e);
  endtask
  // status with the idle bit masked
  task automatic rs(input logic [7:0] e);
    logic [7:0] v;
    rd(3'h2, v);
    chk("status", v & 8'hEF, e);
  endtask
  task automatic send(input logic [8:0] d, input logic nine, bad, nz);
    int k;
    // idle line first so the edge detector holds three high samples
    repeat (16) @(posedge mclk);
    m_data <= d;
    m_nine <= nine;
    m_bad <= bad;
    m_noise <= nz;
    m_go <= 1'b1;
    @(posedge mclk);
    m_go <= 1'b0;
    @(posedge mclk);
    for (k = 0; m_busy !== 1'b0 && k < 1000; k++) @(posedge mclk);
    if (k == 1000) failures++;
    repeat (4) @(posedge mclk);
  endtask
  // watchdog
  initial
  begin
    repeat (60000) @(posedge mclk);
    failures++;
    test_done;
  end
  // main sequence
  initial
  begin
    {rst, wr_s, rd_s, m_go, m_nine, m_bad, m_noise, m_inv} = 8'h80;
    {addr, wdata, m_data} = '0;
    seed = 85810;
    failures = 0;
    samples_checked = 0;
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    for (int a = 0; a < 8; a++) rc(a[2:0], 8'h00, "reset");
    wr(3'h6, 8'h02);
    send(9'h05A, 0, 0, 0);
    rs(8'h00);
    wr(3'h1, 8'h04);
    $display("reset and enable done");
    for (int i = 0; i < 8; i++)
    begin
      b = i == 0 ? 8'h00 : i == 1 ? 8'hFF : 8'($random(seed));
      send({1'b0, b}, 0, 0, 0);
      rs(8'h20);
      rc(3'h4, b, "data");
      rs(8'h00);
    end
    $display("random characters done");
    send(9'h011, 0, 0, 0);
    send(9'h022, 0, 0, 0);
    rs(8'h28);
    rc(3'h4, 8'h11, "kept data");
    rs(8'h00);
    send(9'h03C, 0, 1, 0);
    send(9'h066, 0, 0, 0);
    // low stop bit starts false frames; let them end while framing is set
    repeat (400) @(posedge mclk);
    rs(8'h22);
    rc(3'h4, 8'h3C, "framed data");
    send(9'h04B, 0, 0, 1);
    rs(8'h24);
    rc(3'h4, 8'h4B, "noisy data");
    $display("error flags done");
    m_inv <= 1'b1;
    wr(3'h3, 8'h10);
    send(9'h0C3, 0, 0, 0);
    rs(8'h20);
    rc(3'h4, 8'hC3, "inverted data");
    m_inv <= 1'b0;
    wr(3'h3, 8'h00);
    wr(3'h0, 8'h10);
    for (int n = 0; n < 2; n++)
    begin
      send({n[0], 8'h96}, 1, 0, 0);
      rs(8'h20);
      rc(3'h3, {n[0], 7'h00}, "ninth bit");
      rc(3'h4, 8'h96, "nine bit data");
    end
    $display("inversion and nine bit done");
    wr(3'h0, 8'h08);
    wr(3'h1, 8'h06);
    send(9'h035, 0, 0, 0);
    rs(8'h00);
    rc(3'h1, 8'h06, "asleep");
    send(9'h0A5, 0, 0, 0);
    rc(3'h1, 8'h04, "mark wake");
    rs(8'h20);
    rc(3'h4, 8'hA5, "mark data");
    repeat (400) @(posedge mclk);
    rd(3'h2, q);
    rd(3'h4, q);
    wr(3'h0, 8'h00);
    wr(3'h1, 8'h06);
    send(9'h000, 0, 0, 0);
    rs(8'h00);
    repeat (400) @(posedge mclk);
    rc(3'h1, 8'h04, "idle wake");
    rc(3'h2, 8'h00, "no idle");
    $display("wakeup done");
    for (int t = 0; t < 2; t++)
    begin
      wr(3'h0, t == 0 ? 8'h00 : 8'h04);
      send(9'h081, 0, 0, 0);
      rs(8'h20);
      rd(3'h4, q);
      repeat (400) @(posedge mclk);
      rc(3'h2, 8'h10, "idle");
      rd(3'h4, q);
      repeat (400) @(posedge mclk);
      rc(3'h2, 8'h00, "idle rearm");
    end
    $display("idle done");
    test_done;
  end
endmodule
`default_nettype wire
